// ---- hdl/lst_pkg.sv ----
// Constants for the link module loopback self-test sequencer.
// Assumes a 40 MHz clock and an AXI4-Lite master for the registers.
package lst_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CYCLE_MS        = 1000;
  localparam int unsigned CYCLE_LIMIT_CYC = CLK_HZ / 1000 * CYCLE_MS;
  localparam int unsigned CHECK_TMO_US    = 200;
  localparam int unsigned CHECK_TMO_CYC   = CLK_HZ / 1_000_000 * CHECK_TMO_US;
  localparam int unsigned BLINK_CYC       = 4;
  // ----------------------------------------------------------------
  // Mode and patterns
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_LOOPBACK = 4'hF;
  localparam logic [7:0] PATTERN_RESET = 8'h55;
  localparam logic [7:0] PATTERN_STEP  = 8'h01;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_LED_STATUS = 8'h00;
  localparam logic [7:0] REG_LED_CLEAR  = 8'h04;
  localparam logic [7:0] REG_PASS_COUNT = 8'h08;
  localparam logic [7:0] REG_PATTERN    = 8'h0C;
  // LED status bit positions
  localparam int unsigned BIT_CPU_ERR  = 0;
  localparam int unsigned BIT_232_ERR  = 1;
  localparam int unsigned BIT_422_ERR  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    ST_IDLE, ST_CPU_WR, ST_CPU_RD, ST_S232, ST_S422
  } lst_state_t;
endpackage

// ---- hdl/lst_loopback_test.sv ----
// Loopback self-test sequencer: CPU scratch register, RS-232C and RS-422 echo.
// Assumes a CPU port with same-cycle-free handshake and byte echo ports.
// Summary of operation
// - Controller check writes scratch register, reads it back, compares.
// - Readback mismatch flags a controller check error.
// - Pass: change value, repeat; access LED flashes; error lights error LED.
// - RS-232C check sends data, expects same echo, then alters data.
// - Missing echo, as with no cable, counts as a serial failure.
// - RS-232C send/receive LEDs flash on pass; error LED lights on fail.
// - RS-422 check echoes data, flashes its LEDs, lights error on fail.
// - A failed check never halts the cycle of checks.
// - Test runs only with loopback mode code, starting after reset.
// - Order controller, RS-232C, RS-422, repeat; each cycle within a second.
// - Module-ready output stays low during self-test.
// - Error LEDs stay lit until software writes the clear location.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
module lst_loopback_test
  import lst_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  mode_select,
  output logic             module_ready_input,
  output logic             cpu_req,
  output logic             cpu_we,
  output logic [15:0]      cpu_check_scratch_register,
  input  wire logic        cpu_ack,
  input  wire logic [15:0] cpu_rdata,
  output logic             tx232_valid,
  output logic [7:0]       tx232_data,
  input  wire logic        rx232_valid,
  input  wire logic [7:0]  rx232_data,
  output logic             tx422_valid,
  output logic [7:0]       tx422_data,
  input  wire logic        rx422_valid,
  input  wire logic [7:0]  rx422_data,
  output logic             cpu_error_led,
  output logic             cpu_access_led,
  output logic             rs232_error_led,
  output logic             rs232_send_led,
  output logic             rs232_recv_led,
  output logic             rs422_error_led,
  output logic             rs422_send_led,
  output logic             rs422_recv_led,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import lst_pkg::*;

  // ----------------------------------------------------------------
  // Mode pin synchroniser
  // ----------------------------------------------------------------
  logic [3:0] mode_s1_q, mode_s2_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_s1_q <= 4'h0;
      mode_s2_q <= 4'h0;
    end
    else
    begin
      mode_s1_q <= mode_select;
      mode_s2_q <= mode_s1_q;
    end
  end
  logic test_mode;
  assign test_mode = (mode_s2_q == MODE_LOOPBACK);

  function automatic logic [7:0] next_pattern(input logic [7:0] p);
    return p + PATTERN_STEP;
  endfunction

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  lst_state_t state_q, state_d;
  logic [7:0]  pat_q, pat_d;
  logic [15:0] tmo_q, tmo_d;
  logic [2:0]  err_q, err_d;
  logic [15:0] pass_q, pass_d;
  logic        req_q, req_d, we_q, we_d;
  logic        t232_q, t232_d, t422_q, t422_d;
  logic        clr_pulse;
  logic [2:0]  clr_mask;
  logic        fail;
  logic [2:0]  blink_set;

  always_comb
  begin
    state_d   = state_q;
    pat_d     = pat_q;
    tmo_d     = tmo_q + 16'h0_001;
    err_d     = err_q;
    pass_d    = pass_q;
    req_d     = 1'b0;
    we_d      = we_q;
    t232_d    = 1'b0;
    t422_d    = 1'b0;
    fail      = 1'b0;
    blink_set = 3'h0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (test_mode)
        begin
          state_d = ST_CPU_WR;
          tmo_d   = 16'h0_000;
        end
      end
      ST_CPU_WR:
      begin
        req_d = !cpu_ack;
        we_d  = 1'b1;
        if (cpu_ack)
        begin
          state_d = ST_CPU_RD;
          tmo_d   = 16'h0_000;
          we_d    = 1'b0;
        end
      end
      ST_CPU_RD:
      begin
        req_d = !cpu_ack;
        we_d  = 1'b0;
        if (cpu_ack)
        begin
          if (cpu_rdata != {8'h00, pat_q})
            fail = 1'b1;
          else
            blink_set[0] = 1'b1;
          state_d = ST_S232;
          tmo_d   = 16'h0_000;
          t232_d  = 1'b1;
        end
      end
      ST_S232:
      begin
        if (rx232_valid)
        begin
          if (rx232_data != pat_q)
            fail = 1'b1;
          else
            blink_set[1] = 1'b1;
          state_d = ST_S422;
          tmo_d   = 16'h0_000;
          t422_d  = 1'b1;
        end
      end
      ST_S422:
      begin
        if (rx422_valid)
        begin
          if (rx422_data != pat_q)
            fail = 1'b1;
          else
            blink_set[2] = 1'b1;
          state_d = ST_CPU_WR;
          tmo_d   = 16'h0_000;
          pat_d   = next_pattern(pat_q);
          pass_d  = pass_q + 16'h0_001;
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
    // missing echo or answer times out as failure
    if (state_q != ST_IDLE && tmo_q == 16'(CHECK_TMO_CYC - 1))
    begin
      fail   = 1'b1;
      tmo_d  = 16'h0_000;
      req_d  = 1'b0;
      unique case (state_q)
        ST_CPU_WR, ST_CPU_RD:
        begin
          state_d = ST_S232;
          t232_d  = 1'b1;
        end
        ST_S232:
        begin
          state_d = ST_S422;
          t422_d  = 1'b1;
        end
        default:
        begin
          state_d = ST_CPU_WR;
          pat_d   = next_pattern(pat_q);
          pass_d  = pass_q + 16'h0_001;
        end
      endcase
    end
    if (!test_mode)
      state_d = ST_IDLE;
    if (clr_pulse)
      err_d = err_q & ~clr_mask;
    if (fail)
    begin
      unique case (state_q)
        ST_S232: err_d[BIT_232_ERR] = 1'b1;
        ST_S422: err_d[BIT_422_ERR] = 1'b1;
        default: err_d[BIT_CPU_ERR] = 1'b1;
      endcase
    end
  end

  // LED flash toggles on each passing check
  logic [2:0] flash_q, flash_d;
  always_comb
  begin
    flash_d = flash_q ^ blink_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      pat_q   <= PATTERN_RESET;
      tmo_q   <= 16'h0_000;
      err_q   <= 3'h0;
      pass_q  <= 16'h0_000;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      t232_q  <= 1'b0;
      t422_q  <= 1'b0;
      flash_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      pat_q   <= pat_d;
      tmo_q   <= tmo_d;
      err_q   <= err_d;
      pass_q  <= pass_d;
      req_q   <= req_d;
      we_q    <= we_d;
      t232_q  <= t232_d;
      t422_q  <= t422_d;
      flash_q <= flash_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // ready low in self-test
  assign module_ready_input         = 1'b0;
  assign cpu_req                    = req_q;
  assign cpu_we                     = we_q;
  assign cpu_check_scratch_register = {8'h00, pat_q};
  assign tx232_valid                = t232_q;
  assign tx232_data                 = pat_q;
  assign tx422_valid                = t422_q;
  assign tx422_data                 = pat_q;
  assign cpu_error_led              = err_q[BIT_CPU_ERR];
  assign cpu_access_led             = flash_q[0];
  assign rs232_error_led            = err_q[BIT_232_ERR];
  assign rs232_send_led             = flash_q[1];
  assign rs232_recv_led             = flash_q[1];
  assign rs422_error_led            = err_q[BIT_422_ERR];
  assign rs422_send_led             = flash_q[2];
  assign rs422_recv_led             = flash_q[2];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0]  awa_q, awa_d;
  logic [2:0]  wd_q, wd_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;

  always_comb
  begin
    aw_d      = aw_q;
    w_d       = w_q;
    awa_d     = awa_q;
    wd_d      = wd_q;
    b_d       = b_q;
    bresp_d   = bresp_q;
    r_d       = r_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    clr_pulse = 1'b0;
    clr_mask  = wd_q;
    if (s_axi_awvalid && !aw_q && !b_q)
    begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !b_q)
    begin
      w_d  = 1'b1;
      wd_d = s_axi_wstrb[0] ? s_axi_wdata[2:0] : 3'h0;
    end
    if (aw_q && w_q)
    begin
      aw_d    = 1'b0;
      w_d     = 1'b0;
      b_d     = 1'b1;
      bresp_d = (awa_q == REG_LED_CLEAR) ? RESP_OKAY : RESP_SLVERR;
      clr_pulse = (awa_q == REG_LED_CLEAR);
    end
    if (b_q && s_axi_bready)
      b_d = 1'b0;
    if (s_axi_arvalid && !r_q)
    begin
      r_d     = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (s_axi_araddr)
        REG_LED_STATUS: rdata_d = {29'h0, err_q};
        REG_PASS_COUNT: rdata_d = {16'h0_000, pass_q};
        REG_PATTERN:    rdata_d = {24'h00_0000, pat_q};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    else if (r_q && s_axi_rready)
      r_d = 1'b0;
    // Ready outputs registered from next state
    awrdy_d = !aw_d && !b_d;
    wrdy_d  = !w_d && !b_d;
    arrdy_d = !r_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q    <= 1'b0;
      w_q     <= 1'b0;
      awa_q   <= 8'h00;
      wd_q    <= 3'h0;
      b_q     <= 1'b0;
      bresp_q <= RESP_OKAY;
      r_q     <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      awrdy_q <= 1'b1;
      wrdy_q  <= 1'b1;
      arrdy_q <= 1'b1;
    end
    else
    begin
      aw_q    <= aw_d;
      w_q     <= w_d;
      awa_q   <= awa_d;
      wd_q    <= wd_d;
      b_q     <= b_d;
      bresp_q <= bresp_d;
      r_q     <= r_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      awrdy_q <= awrdy_d;
      wrdy_q  <= wrdy_d;
      arrdy_q <= arrdy_d;
    end
  end

  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // cycles since last controller check entry
  logic [25:0] lap_q, lap_d;
  always_comb
  begin
    lap_d = lap_q + 26'h000_0001;
    if (state_q != ST_CPU_WR && state_d == ST_CPU_WR)
      lap_d = 26'h000_0000;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lap_q <= 26'h000_0000;
    else
      lap_q <= lap_d;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // ready never high
  ready_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !module_ready_input) else $error("ready high in self-test");
  cpu_mismatch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_CPU_RD && cpu_ack && cpu_rdata != {8'h00, pat_q})
    |=> cpu_error_led) else $error("cpu mismatch not flagged");
  err_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rs232_error_led && !clr_pulse) |=> rs232_error_led) else $error("error led dropped");
  echo_missing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_S422 && tmo_q == 16'(CHECK_TMO_CYC - 1)) |=> rs422_error_led)
    else $error("missing echo not flagged");
  fail_advance_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_S232 && rx232_valid && test_mode) |=> state_q == ST_S422)
    else $error("sequencer did not advance");
  pattern_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_S422 && state_d == ST_CPU_WR) |=> pat_q == $past(pat_q) + 8'h01)
    else $error("pattern not incremented");
  mode_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !test_mode |=> state_q == ST_IDLE) else $error("ran outside loopback mode");
  send232_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q != ST_S232 && state_d == ST_S232) |=> tx232_valid)
    else $error("rs232 send missing");
  cycle_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q != ST_IDLE) |-> (lap_q < 26'(CYCLE_LIMIT_CYC)))
    else $error("cycle exceeds one second");
endmodule

// ---- testbench/lst_far_end.sv ----
// Far-end models: controller CPU port and looped-back serial cables.
// Assumes every input is sampled and every output updated at the rising aclk edge.
module lst_echo (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       cable,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       busy_q;
  logic [2:0] cnt_q;
  logic [7:0] byte_q;
  always @(posedge aclk)
  begin
    rx_valid <= 1'h0;
    if (!aresetn)
    begin
      busy_q  <= 1'h0;
      rx_data <= 8'h00;
    end
    else if (tx_valid && cable)
    begin
      busy_q <= 1'h1;
      cnt_q  <= 3'h0;
      byte_q <= tx_data;
    end
    else if (busy_q && cnt_q == (slow ? 3'h6 : 3'h1))
    begin
      rx_valid <= 1'h1;
      rx_data  <= byte_q;
      busy_q   <= 1'h0;
    end
    else
    begin
      cnt_q   <= cnt_q + 3'h1;
      rx_data <= ~rx_data;
    end
  end
endmodule

module lst_cpu_end (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        slow,
  input  wire logic        corrupt,
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic [15:0] cpu_wdata,
  output logic             cpu_ack,
  output logic [15:0]      cpu_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] store_q;
  logic [2:0]  cnt_q;
  always @(posedge aclk)
  begin
    cpu_ack <= 1'h0;
    if (!aresetn)
    begin
      cnt_q     <= 3'h0;
      store_q   <= 16'h0000;
      cpu_rdata <= 16'h0000;
    end
    else if (cpu_req && !cpu_ack && cnt_q == (slow ? 3'h6 : 3'h1))
    begin
      cpu_ack <= 1'h1;
      cnt_q   <= 3'h0;
      if (cpu_we)
        store_q <= cpu_wdata;
      cpu_rdata <= cpu_we ? ~store_q : store_q ^ {15'h0, corrupt};
    end
    else
    begin
      cnt_q     <= (cpu_req && !cpu_ack) ? cnt_q + 3'h1 : 3'h0;
      cpu_rdata <= ~cpu_rdata;
    end
  end
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the loopback self-test sequencer.
// Assumes the far-end models of lst_far_end.sv and the register map of lst_pkg.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lst_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic slow; logic corrupt; logic c232; logic c422; logic [4:0] flash; logic [2:0] err;
  } lst_tb_row_t;
  // unplugged rows stand for absent ports
  lst_tb_row_t rows [4] = '{'{1'h0, 1'h0, 1'h1, 1'h1, 5'h1F, 3'h0},
    '{1'h1, 1'h1, 1'h1, 1'h0, 5'h0C, 3'h5}, '{1'h0, 1'h0, 1'h0, 1'h1, 5'h13, 3'h2},
    '{1'h1, 1'h0, 1'h1, 1'h1, 5'h1F, 3'h0}};
  logic        aclk = 1'h0, aresetn = 1'h0, slow = 1'h0, corrupt = 1'h0;
  logic        cable232 = 1'h1, cable422 = 1'h1;
  logic [3:0]  mode_select = 4'h0, s_axi_wstrb = 4'hF;
  logic        module_ready_input, cpu_req, cpu_we, cpu_ack;
  logic [15:0] cpu_check_scratch_register, cpu_rdata;
  logic        tx232_valid, rx232_valid, tx422_valid, rx422_valid;
  logic [7:0]  tx232_data, rx232_data, tx422_data, rx422_data;
  logic        cpu_error_led, cpu_access_led, rs232_error_led, rs232_send_led;
  logic        rs232_recv_led, rs422_error_led, rs422_send_led, rs422_recv_led;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, stage = 2'h2;
  logic [7:0]  last_pat = PATTERN_RESET;
  logic [4:0]  fl, fl_prev;
  int          n_mismatch = 0, comparisons = 0, cyc = 0, tog [5] = '{0, 0, 0, 0, 0};

  always #12.5 aclk = ~aclk;
  assign fl = {cpu_access_led, rs232_send_led, rs232_recv_led, rs422_send_led, rs422_recv_led};

  lst_loopback_test dut_u (.aclk, .aresetn, .mode_select, .module_ready_input, .cpu_req, .cpu_we,
    .cpu_check_scratch_register, .cpu_ack, .cpu_rdata, .tx232_valid, .tx232_data, .rx232_valid,
    .rx232_data, .tx422_valid, .tx422_data, .rx422_valid, .rx422_data, .cpu_error_led,
    .cpu_access_led, .rs232_error_led, .rs232_send_led, .rs232_recv_led, .rs422_error_led,
    .rs422_send_led, .rs422_recv_led, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  lst_cpu_end cpu_u (.aclk, .aresetn, .slow, .corrupt, .cpu_req, .cpu_we,
    .cpu_wdata(cpu_check_scratch_register), .cpu_ack, .cpu_rdata);
  lst_echo e232_u (.aclk, .aresetn, .cable(cable232), .slow, .tx_valid(tx232_valid),
    .tx_data(tx232_data), .rx_valid(rx232_valid), .rx_data(rx232_data));
  lst_echo e422_u (.aclk, .aresetn, .cable(cable422), .slow, .tx_valid(tx422_valid),
    .tx_data(tx422_data), .rx_valid(rx422_valid), .rx_data(rx422_data));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic wait_pass(input int k);
    logic [31:0] p0, p;
    logic [1:0]  r;
    axi_rd(REG_PASS_COUNT, p0, r);
    do
      axi_rd(REG_PASS_COUNT, p, r);
    while (p < p0 + k);
  endtask
  // ------------------------------------------------------------
  // Monitor and sequence
  // ------------------------------------------------------------
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  always @(posedge aclk)
  begin
    for (int k = 0; k < 5; k++)
      if (fl[k] !== fl_prev[k])
        tog[k]++;
    fl_prev <= fl;
    if (aresetn)
    begin
      chk(module_ready_input, 32'h0000_0000);
      if (cpu_req && cpu_we && cpu_ack)
      begin
        chk(stage, 32'h0000_0002);
        chk(cpu_check_scratch_register, {8'h00, last_pat});
        last_pat <= last_pat + 8'h01;
        stage    <= 2'h0;
      end
      if (tx232_valid)
      begin
        chk(stage, 32'h0000_0000);
        chk(tx232_data, 8'(last_pat - 8'h01));
        stage <= 2'h1;
      end
      if (tx422_valid)
      begin
        chk(stage, 32'h0000_0001);
        chk(tx422_data, 8'(last_pat - 8'h01));
        stage <= 2'h2;
      end
    end
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [4:0]  act;
    int          t0 [5];
    logic [7:0]  bad [4];
    bad = '{REG_LED_STATUS, REG_PASS_COUNT, REG_PATTERN, 8'h10};
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(REG_LED_STATUS, d, r);
    chk(d, 32'h0000_0000);
    axi_rd(REG_PATTERN, d, r);
    chk(d, {24'h00_0000, PATTERN_RESET});
    chk(cpu_req, 32'h0000_0000);
    $display("test reset done");
    mode_select <= MODE_LOOPBACK;
    foreach (bad[i])
    begin
      axi_wr(bad[i], 32'hFFFF_FFFF, r);
      chk(r, RESP_SLVERR);
    end
    axi_rd(8'h10, d, r);
    chk(d, 32'h0000_0000);
    chk(r, RESP_SLVERR);
    $display("test refusals done");
    foreach (rows[i])
    begin
      {slow, corrupt, cable232, cable422} <= rows[i][11:8];
      wait_pass(1);
      axi_wr(REG_LED_CLEAR, 32'h0000_0007, r);
      chk(r, RESP_OKAY);
      t0 = tog;
      wait_pass(2);
      for (int k = 0; k < 5; k++)
        act[k] = (tog[k] != t0[k]);
      chk(act, rows[i].flash);
      axi_rd(REG_LED_STATUS, d, r);
      chk(d, rows[i].err);
      chk({rs422_error_led, rs232_error_led, cpu_error_led}, rows[i].err);
      $display("test row %0d done", i);
    end
    corrupt <= 1'h1;
    wait_pass(2);
    corrupt <= 1'h0;
    wait_pass(2);
    axi_rd(REG_LED_STATUS, d, r);
    chk(d, 32'h0000_0001);
    chk(cpu_error_led, 32'h0000_0001);
    axi_wr(REG_LED_CLEAR, 32'h0000_0001, r);
    axi_rd(REG_LED_STATUS, d, r);
    chk(d, 32'h0000_0000);
    $display("test sticky done");
    end_of_test();
  end
endmodule
